/* File: design/plc_load_div.sv */
// load clock divider: pixel enable in, load clock and its half and quarter
// assumes pix_en is a one-cycle enable on the core clock
`default_nettype none
module plc_load_div (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       pix_en,
  input  wire logic [2:0] div_sel,
  output logic            ld_q,
  output logic            ld_rise,
  output logic            half_q,
  output logic            quarter_q,
  output logic            quarter_rise
);
  import plc_pkg::*;

  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic [1:0] sub_ff;
  logic [2:0] last;
  logic [2:0] hi_len;

  // ----------------------------------------------------------------------------
  // divisor decode
  // ----------------------------------------------------------------------------
  function automatic logic [2:0] div_last(input logic [2:0] sel);
    case (sel)
      PLC_DIV2: div_last = 3'h1;
      PLC_DIV3: div_last = 3'h2;
      PLC_DIV4: div_last = 3'h3;
      PLC_DIV5: div_last = 3'h4;
      PLC_DIV8: div_last = 3'h7;
      default:  div_last = 3'h0;
    endcase
  endfunction

  assign last   = div_last(div_sel);
  assign hi_len = 3'((4'(last) + 4'h1) >> 1);
  assign nxt_cnt = (cnt_ff >= last) ? 3'h0 : 3'(cnt_ff + 3'h1);
  assign ld_rise = pix_en && (nxt_cnt == 3'h0);
  assign quarter_rise = ld_rise && (sub_ff == 2'h0);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff <= 3'h0;
    end else if (pix_en) begin
      cnt_ff <= nxt_cnt;
    end
  end

  // RULE1: load clock divide
  // divide by 1 is high for the cycle after each pixel enable,
  // so pixel enables must leave at least one idle cycle between them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ld_q <= 1'b0;
    end else if (last == 3'h0) begin
      ld_q <= pix_en;
    end else if (pix_en) begin
      ld_q <= (nxt_cnt < hi_len);
    end
  end

  // RULE19: binary half and quarter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sub_ff    <= 2'h0;
      half_q    <= 1'b0;
      quarter_q <= 1'b0;
    end else if (ld_rise) begin
      sub_ff    <= 2'(sub_ff + 2'h1);
      half_q    <= ~sub_ff[0];
      quarter_q <= (sub_ff == 2'h0) || (sub_ff == 2'h1);
    end
  end
endmodule
`default_nettype wire

/* File: design/plc_pkg.sv */
// types for the pixel load clock control block
// assumes plc_regs.svh holds the numeric constants
`default_nettype none
package plc_pkg;
  typedef enum logic [1:0] {
    PLC_AL_IDLE = 2'b00,
    PLC_AL_WAIT = 2'b01,
    PLC_AL_STOP = 2'b10,
    PLC_AL_DONE = 2'b11
  } plc_align_type;
  typedef enum logic [2:0] {
    PLC_DIV1 = 3'h0,
    PLC_DIV2 = 3'h1,
    PLC_DIV3 = 3'h2,
    PLC_DIV4 = 3'h3,
    PLC_DIV5 = 3'h4,
    PLC_DIV8 = 3'h5
  } plc_ldiv_type;
endpackage
`default_nettype wire

/* File: design/plc_regs.svh */
// constants for the pixel load clock control block
// assumes a single core clock at 25 MHz
`ifndef PLC_REGS_SVH
`define PLC_REGS_SVH
// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define PLC_ADDR_W          4
`define PLC_OFF_CTRL        4'h0
`define PLC_OFF_LDIV        4'h1
`define PLC_OFF_VOSC0       4'h2
`define PLC_OFF_VOSC1       4'h3
`define PLC_OFF_VOSC2       4'h4
`define PLC_OFF_MOSC        4'h5
`define PLC_OFF_STATUS      4'h6
// ----------------------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------------------
`define PLC_CTRL_RESET_BIT  0
`define PLC_CTRL_PS_LSB     1
`define PLC_CTRL_SEL_LSB    4
`define PLC_CTRL_RST_VAL    6'h00
// ----------------------------------------------------------------------------
// oscillator word fields
// ----------------------------------------------------------------------------
`define PLC_IDX_MSB         20
`define PLC_IDX_LSB         17
`define PLC_P_MSB           16
`define PLC_P_LSB           10
`define PLC_M_MSB           9
`define PLC_M_LSB           7
`define PLC_Q_MSB           6
`define PLC_Q_LSB           0
`define PLC_IDX_MUXMEM      4'hf
`define PLC_P_OFFSET        3
`define PLC_Q_OFFSET        2
`define PLC_OSC_RST_VAL     21'h000000
`define PLC_LDIV_RST_VAL    3'h0
`endif

/* File: design/plc_top.sv */
// pixel load clock control: load clock divider, gated load clock,
// one-time video clock alignment stop, output disable, register file
// assumes PIX_EN marks pixel clock periods on CORE_CLK and the video
// and memory oscillator edges arrive as enables VID_OSC_EN and MEM_OSC_EN
//
// Added by the designer: strobed register access and the placing of the registers.
`default_nettype none
`include "plc_regs.svh"

// How it works
// RULE1: load clock is pixel clock divided by 1,2,3,4,5 or 8, plus half and quarter.
// RULE2: enable input is synchronised to the load clock before gating.
// RULE3: gated load clock low when enable low, follows load clock when high.
// RULE4: alignment reset happens the first time the control reset bit is set.
// RULE5: next quarter clock rise stops true video clock high, complement low.
// RULE6: following quarter clock rise releases both video clock outputs.
// RULE7: disable pin floats all outputs except crystal and error outputs.
// RULE8: oscillator word is index, P count, post divide, Q count, MSB first.
// RULE9: host shifts the word in serially, LSB first, with address and framing; the code takes the word whole on WDATA at a WR strobe instead.
// RULE10: P field is feedback count minus 3, Q field reference count minus 2.
// RULE11: host keeps Q 3..129, P 4..130, reference over Q 200 kHz..1 MHz.
// RULE12: host keeps oscillator in 65..165 MHz video, 52..120 MHz memory.
// RULE13: each of three video settings has its own prescale select bit.
// RULE14: host loads control word with prescale bits before oscillator word.
// RULE15: host never changes prescale bit of the active video setting.
// RULE16: post divide field selects divisor two to the field value.
// RULE17: index 1111 stops video oscillator, both channels use memory oscillator.
// RULE18: index in bits 20..17, Q in 6..0, P and post divide between.
// RULE19: half and quarter load clocks are binary divisions, rises aligned.
// RULE20: later reset bit settings do nothing until power up again.
// RULE21: dividers keep running while outputs are disabled.
module plc_top (
  input  wire logic                   CORE_CLK,
  input  wire logic                   RSTN,
  input  wire logic [`PLC_ADDR_W-1:0] ADDR,
  input  wire logic [20:0]            WDATA,
  input  wire logic                   WR,
  input  wire logic                   RD,
  output logic      [20:0]            RDATA,
  input  wire logic                   PIX_EN,
  input  wire logic                   VID_OSC_EN,
  input  wire logic                   MEM_OSC_EN,
  input  wire logic                   ENABLE_PIN,
  input  wire logic                   OUTPUT_DISABLE_N,
  input  wire logic                   XTAL_IN,
  input  wire logic                   PROG_ERR,
  output logic                        LOAD_CLOCK,
  output logic                        LOAD_CLOCK_OE_N,
  output logic                        LOAD_CLOCK_HALF,
  output logic                        LOAD_CLOCK_HALF_OE_N,
  output logic                        LOAD_CLOCK_QUARTER,
  output logic                        LOAD_CLOCK_QUARTER_OE_N,
  output logic                        GATED_LOAD_CLOCK,
  output logic                        GATED_LOAD_CLOCK_OE_N,
  output logic                        VIDEO_CLOCK_OUT,
  output logic                        VIDEO_CLOCK_OUT_N,
  output logic                        VIDEO_CLOCK_OE_N,
  output logic                        MEMORY_CLOCK_OUT,
  output logic                        MEMORY_CLOCK_OE_N,
  output logic                        CRYSTAL_OUT,
  output logic                        PROGRAM_ERROR_OUT
);
  import plc_pkg::*;

  // ----------------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------------
  logic [5:0]          control_word_reg_ff;
  logic [2:0]          load_divisor_reg_ff;
  logic [20:0]         video_osc_setting_regs_ff [3];
  logic [20:0]         memory_osc_setting_reg_ff;
  logic [20:0]         nxt_rdata;
  logic                reset_req_ff;
  logic [1:0]          sel;
  logic [20:0]         vid_word;
  logic                vid_muxmem;

  function automatic logic [21:0] fld(input logic [20:0] w, input int msb, input int lsb);
    fld = 22'((w >> lsb) & ((21'h1 << (msb - lsb + 1)) - 21'h1));
  endfunction

  // RULE13: control word holds reset, prescale selects and active setting
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      control_word_reg_ff <= `PLC_CTRL_RST_VAL;
      reset_req_ff        <= 1'b0;
    end else begin
      reset_req_ff <= 1'b0;
      if (WR && (ADDR == `PLC_OFF_CTRL)) begin
        control_word_reg_ff <= WDATA[5:0];
        // RULE4: reset bit request
        reset_req_ff        <= WDATA[`PLC_CTRL_RESET_BIT];
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      load_divisor_reg_ff <= `PLC_LDIV_RST_VAL;
    end else if (WR && (ADDR == `PLC_OFF_LDIV)) begin
      load_divisor_reg_ff <= WDATA[2:0];
    end
  end

  // RULE8: index, P, post divide, Q
  // RULE10: P, Q kept as offsets
  // RULE18: oscillator words stored whole
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      for (int i = 0; i < 3; i++) begin
        video_osc_setting_regs_ff[i] <= `PLC_OSC_RST_VAL;
      end
      memory_osc_setting_reg_ff <= `PLC_OSC_RST_VAL;
    end else if (WR) begin
      if (ADDR == `PLC_OFF_VOSC0) begin
        video_osc_setting_regs_ff[0] <= WDATA;
      end else if (ADDR == `PLC_OFF_VOSC1) begin
        video_osc_setting_regs_ff[1] <= WDATA;
      end else if (ADDR == `PLC_OFF_VOSC2) begin
        video_osc_setting_regs_ff[2] <= WDATA;
      end else if (ADDR == `PLC_OFF_MOSC) begin
        memory_osc_setting_reg_ff <= WDATA;
      end
    end
  end

  assign sel = control_word_reg_ff[`PLC_CTRL_SEL_LSB +: 2];
  assign vid_word = (sel == 2'h3) ? video_osc_setting_regs_ff[2]
                                  : video_osc_setting_regs_ff[sel];
  // RULE17: index 1111 routes memory oscillator
  assign vid_muxmem = (vid_word[`PLC_IDX_MSB:`PLC_IDX_LSB] == `PLC_IDX_MUXMEM);

  // ----------------------------------------------------------------------------
  // load clocks and gated load clock
  // ----------------------------------------------------------------------------
  logic ld_q;
  logic ld_rise;
  logic half_q;
  logic quarter_q;
  logic quarter_rise;
  logic [2:0] en_sync_ff;
  logic en_pin_ok_ff;
  logic en_ld_ff;

  plc_load_div u_div (
    .clk          (CORE_CLK),
    .rst_n        (RSTN),
    .pix_en       (PIX_EN),
    .div_sel      (load_divisor_reg_ff),
    .ld_q         (ld_q),
    .ld_rise      (ld_rise),
    .half_q       (half_q),
    .quarter_q    (quarter_q),
    .quarter_rise (quarter_rise)
  );

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      en_sync_ff   <= 3'h0;
      en_pin_ok_ff <= 1'b0;
    end else begin
      en_sync_ff <= {en_sync_ff[1:0], ENABLE_PIN};
      if (en_sync_ff[2] == en_sync_ff[1]) begin
        en_pin_ok_ff <= en_sync_ff[2];
      end
    end
  end

  // RULE2: enable resampled at load clock rise
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      en_ld_ff <= 1'b0;
    end else if (ld_rise) begin
      en_ld_ff <= en_pin_ok_ff;
    end
  end

  // ----------------------------------------------------------------------------
  // one-time video clock alignment
  // ----------------------------------------------------------------------------
  plc_align_type al_ff;
  logic [2:0]    vdiv_ff;
  logic [7:0]    vcnt_ff;
  logic          video_oscillator_ff;
  logic [7:0]    mcnt_ff;
  logic          mclk_ff;
  logic [2:0]    mdiv;
  logic          vsrc_en;

  // RULE4: first setting arms the stop
  // RULE5: stop at next quarter rise
  // RULE6: release at following quarter rise
  // RULE20: done state never rearms
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      al_ff <= PLC_AL_IDLE;
    end else begin
      case (al_ff)
        PLC_AL_IDLE: if (reset_req_ff) al_ff <= PLC_AL_WAIT;
        PLC_AL_WAIT: if (quarter_rise) al_ff <= PLC_AL_STOP;
        PLC_AL_STOP: if (quarter_rise) al_ff <= PLC_AL_DONE;
        default:     al_ff <= PLC_AL_DONE;
      endcase
    end
  end

  // RULE16: post divide by two to the field
  assign vdiv_ff = vid_word[`PLC_M_MSB:`PLC_M_LSB];
  assign mdiv    = memory_osc_setting_reg_ff[`PLC_M_MSB:`PLC_M_LSB];
  assign vsrc_en = vid_muxmem ? MEM_OSC_EN : VID_OSC_EN;

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      vcnt_ff <= 8'h00;
      video_oscillator_ff <= 1'b0;
    end else if (vsrc_en) begin
      vcnt_ff <= 8'(vcnt_ff + 8'h01);
      // bit M of the edge count repeats every two to the M plus one edges
      video_oscillator_ff <= vcnt_ff[vdiv_ff];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      mcnt_ff <= 8'h00;
      mclk_ff <= 1'b0;
    end else if (MEM_OSC_EN) begin
      mcnt_ff <= 8'(mcnt_ff + 8'h01);
      mclk_ff <= mcnt_ff[mdiv];
    end
  end

  // ----------------------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------------------
  logic stop_now;
  logic dis_n;

  assign stop_now = (al_ff == PLC_AL_STOP) || ((al_ff == PLC_AL_WAIT) && quarter_rise);
  assign dis_n    = OUTPUT_DISABLE_N;

  // RULE21: dividers run regardless of disable
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      LOAD_CLOCK         <= 1'b0;
      LOAD_CLOCK_HALF    <= 1'b0;
      LOAD_CLOCK_QUARTER <= 1'b0;
      GATED_LOAD_CLOCK   <= 1'b0;
      VIDEO_CLOCK_OUT    <= 1'b1;
      VIDEO_CLOCK_OUT_N  <= 1'b0;
      MEMORY_CLOCK_OUT   <= 1'b0;
      CRYSTAL_OUT        <= 1'b0;
      PROGRAM_ERROR_OUT  <= 1'b1;
    end else begin
      LOAD_CLOCK         <= ld_q;
      LOAD_CLOCK_HALF    <= half_q;
      LOAD_CLOCK_QUARTER <= quarter_q;
      // RULE3: gate low unless enabled
      GATED_LOAD_CLOCK   <= ld_q && en_ld_ff;
      if (stop_now) begin
        VIDEO_CLOCK_OUT   <= 1'b1;
        VIDEO_CLOCK_OUT_N <= 1'b0;
      end else begin
        VIDEO_CLOCK_OUT   <= video_oscillator_ff;
        VIDEO_CLOCK_OUT_N <= ~video_oscillator_ff;
      end
      MEMORY_CLOCK_OUT  <= mclk_ff;
      CRYSTAL_OUT       <= XTAL_IN;
      PROGRAM_ERROR_OUT <= PROG_ERR;
    end
  end

  // RULE7: disable floats outputs except crystal and error
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      LOAD_CLOCK_OE_N         <= 1'b0;
      LOAD_CLOCK_HALF_OE_N    <= 1'b0;
      LOAD_CLOCK_QUARTER_OE_N <= 1'b0;
      GATED_LOAD_CLOCK_OE_N   <= 1'b0;
      VIDEO_CLOCK_OE_N        <= 1'b0;
      MEMORY_CLOCK_OE_N       <= 1'b0;
    end else begin
      LOAD_CLOCK_OE_N         <= ~dis_n;
      LOAD_CLOCK_HALF_OE_N    <= ~dis_n;
      LOAD_CLOCK_QUARTER_OE_N <= ~dis_n;
      GATED_LOAD_CLOCK_OE_N   <= ~dis_n;
      VIDEO_CLOCK_OE_N        <= ~dis_n;
      MEMORY_CLOCK_OE_N       <= ~dis_n;
    end
  end

  // ----------------------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------------------
  always_comb begin
    nxt_rdata = 21'h000000;
    if (ADDR == `PLC_OFF_CTRL) begin
      nxt_rdata = {15'h0000, control_word_reg_ff};
    end else if (ADDR == `PLC_OFF_LDIV) begin
      nxt_rdata = {18'h00000, load_divisor_reg_ff};
    end else if (ADDR == `PLC_OFF_VOSC0) begin
      nxt_rdata = video_osc_setting_regs_ff[0];
    end else if (ADDR == `PLC_OFF_VOSC1) begin
      nxt_rdata = video_osc_setting_regs_ff[1];
    end else if (ADDR == `PLC_OFF_VOSC2) begin
      nxt_rdata = video_osc_setting_regs_ff[2];
    end else if (ADDR == `PLC_OFF_MOSC) begin
      nxt_rdata = memory_osc_setting_reg_ff;
    end else if (ADDR == `PLC_OFF_STATUS) begin
      nxt_rdata = {17'h00000, vid_muxmem, en_ld_ff, al_ff};
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      RDATA <= 21'h000000;
    end else if (RD) begin
      RDATA <= nxt_rdata;
    end else begin
      RDATA <= 21'h000000;
    end
  end

  logic unused_fld;
  assign unused_fld = ^fld(vid_word, `PLC_P_MSB, `PLC_P_LSB);
endmodule
`default_nettype wire

/* File: sim/plc_src_model.sv */
// far-side source model: pixel clock and oscillator edge enables
// assumes one core clock; pixel clock at half core rate
`default_nettype none
module plc_src_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic vid_on,
  output logic      pix_en,
  output logic      vid_en,
  output logic      mem_en
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ph_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) ph_ff <= 1'b0;
    else ph_ff <= !ph_ff;
  end
  assign pix_en = ph_ff;
  assign vid_en = vid_on;
  assign mem_en = 1'b1;
endmodule
`default_nettype wire

/* File: sim/plc_top_asserts.sv */
// checker for the pixel load clock control top ports
// assumes plc_top ports, one core clock and a synchronous active-low reset
`default_nettype none
`include "plc_regs.svh"
module plc_top_chk (
  input wire logic                   CORE_CLK,
  input wire logic                   RSTN,
  input wire logic [`PLC_ADDR_W-1:0] ADDR,
  input wire logic [20:0]            WDATA,
  input wire logic                   WR,
  input wire logic                   RD,
  input wire logic [20:0]            RDATA,
  input wire logic                   ENABLE_PIN,
  input wire logic                   OUTPUT_DISABLE_N,
  input wire logic                   XTAL_IN,
  input wire logic                   PROG_ERR,
  input wire logic                   LOAD_CLOCK,
  input wire logic                   LOAD_CLOCK_OE_N,
  input wire logic                   LOAD_CLOCK_HALF,
  input wire logic                   LOAD_CLOCK_HALF_OE_N,
  input wire logic                   LOAD_CLOCK_QUARTER,
  input wire logic                   LOAD_CLOCK_QUARTER_OE_N,
  input wire logic                   GATED_LOAD_CLOCK,
  input wire logic                   GATED_LOAD_CLOCK_OE_N,
  input wire logic                   VIDEO_CLOCK_OUT,
  input wire logic                   VIDEO_CLOCK_OUT_N,
  input wire logic                   VIDEO_CLOCK_OE_N,
  input wire logic                   MEMORY_CLOCK_OE_N,
  input wire logic                   CRYSTAL_OUT,
  input wire logic                   PROGRAM_ERROR_OUT
);
  import plc_pkg::*;
  logic [5:0] oe_all;
  logic [5:0] en_low_ff;
  assign oe_all = {LOAD_CLOCK_OE_N, LOAD_CLOCK_HALF_OE_N, LOAD_CLOCK_QUARTER_OE_N,
                   GATED_LOAD_CLOCK_OE_N, VIDEO_CLOCK_OE_N, MEMORY_CLOCK_OE_N};
  // cycles the enable pin has been low, saturating
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN || ENABLE_PIN) en_low_ff <= 6'h00;
    else if (en_low_ff != 6'h3f) en_low_ff <= en_low_ff + 6'h01;
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  // ------
  // assertions
  // ------
  chk_oe_float: assert property (!OUTPUT_DISABLE_N |=> oe_all == 6'h3f)
    else $error("output enables not high while disabled");
  chk_oe_drive: assert property (OUTPUT_DISABLE_N |=> oe_all == 6'h00)
    else $error("output enables not low while enabled");
  chk_xtal_pass: assert property ($past(RSTN) |-> CRYSTAL_OUT == $past(XTAL_IN))
    else $error("crystal output does not follow input");
  chk_err_pass: assert property ($past(RSTN) |-> PROGRAM_ERROR_OUT == $past(PROG_ERR))
    else $error("error output does not follow input");
  chk_gated_phase: assert property ($rose(GATED_LOAD_CLOCK) |-> $rose(LOAD_CLOCK))
    else $error("gated load clock rise out of phase");
  chk_gated_off: assert property (en_low_ff >= 6'd60 |-> !GATED_LOAD_CLOCK)
    else $error("gated load clock runs with enable low");
  chk_half_align: assert property ($rose(LOAD_CLOCK_HALF) |-> $rose(LOAD_CLOCK))
    else $error("half load clock rise not aligned");
  chk_quarter_align: assert property ($rose(LOAD_CLOCK_QUARTER) |-> $rose(LOAD_CLOCK_HALF))
    else $error("quarter load clock rise not aligned");
  chk_video_pair: assert property (VIDEO_CLOCK_OUT_N == !VIDEO_CLOCK_OUT)
    else $error("video outputs not complementary");
  chk_osc_readback: assert property ((WR && ADDR == `PLC_OFF_VOSC0) ##2
    (RD && ADDR == `PLC_OFF_VOSC0) |=> RDATA == $past(WDATA, 3))
    else $error("oscillator word read back wrong");
  chk_unmapped_zero: assert property (RD && ADDR > `PLC_OFF_STATUS |=> RDATA == 21'h0)
    else $error("unmapped read not zero");
  cover property ($rose(GATED_LOAD_CLOCK));
  cover property (!OUTPUT_DISABLE_N ##1 oe_all == 6'h3f);
  cover property (VIDEO_CLOCK_OUT [*6]);
endmodule
bind plc_top plc_top_chk i_chk (.*);
`default_nettype wire

/* File: sim/plc_top_tb_top.sv */
// testbench for the pixel load clock control block
// assumes plc_regs.svh on the include path and the source model
`default_nettype none
`include "plc_regs.svh"
module plc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import plc_pkg::*;
  logic clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, en_s = 1, dis_n = 1;
  logic xtal = 0, perr = 1, vid_on = 1;
  logic [3:0] addr = 4'h0;
  logic [20:0] wdata = 21'h0, rdata, rv;
  logic ld, half, qtr, gld, vco, vco_n, mco, xo, eo, pix, ven, men;
  logic ld_oe, half_oe, qtr_oe, gld_oe, vco_oe, mco_oe;
  wire [5:0] mon = {mco, vco, gld, qtr, half, ld};
  int cnt[6];
  int num_errors = 0, n_tests = 0;
  always #20 clk = !clk;
  plc_src_model i_src (.clk(clk), .rst_n(rst_n), .vid_on(vid_on), .pix_en(pix),
    .vid_en(ven), .mem_en(men));
  plc_top i_dut (.CORE_CLK(clk), .RSTN(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
    .RD(rd_s), .RDATA(rdata), .PIX_EN(pix), .VID_OSC_EN(ven), .MEM_OSC_EN(men),
    .ENABLE_PIN(en_s), .OUTPUT_DISABLE_N(dis_n), .XTAL_IN(xtal), .PROG_ERR(perr),
    .LOAD_CLOCK(ld), .LOAD_CLOCK_OE_N(ld_oe), .LOAD_CLOCK_HALF(half),
    .LOAD_CLOCK_HALF_OE_N(half_oe), .LOAD_CLOCK_QUARTER(qtr),
    .LOAD_CLOCK_QUARTER_OE_N(qtr_oe), .GATED_LOAD_CLOCK(gld),
    .GATED_LOAD_CLOCK_OE_N(gld_oe), .VIDEO_CLOCK_OUT(vco), .VIDEO_CLOCK_OUT_N(vco_n),
    .VIDEO_CLOCK_OE_N(vco_oe), .MEMORY_CLOCK_OUT(mco), .MEMORY_CLOCK_OE_N(mco_oe),
    .CRYSTAL_OUT(xo), .PROGRAM_ERROR_OUT(eo));
  // ------
  // helpers
  // ------
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [20:0] e, input logic [20:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic near(input string nm, input int e, input int g);
    n_tests++;
    if (g < e - 1 || g > e + 1) begin
      num_errors++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // word lands whole, lsb in bit 0
  task automatic wr(input logic [3:0] a, input logic [20:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    rv = rdata;
  endtask
  // counts rising edges of every watched output over n cycles
  task automatic run(input int n);
    logic [5:0] p;
    for (int k = 0; k < 6; k++) cnt[k] = 0;
    p = mon;
    repeat (n) begin
      @(posedge clk);
      #1;
      for (int k = 0; k < 6; k++) if (mon[k] === 1'b1 && p[k] === 1'b0) cnt[k]++;
      p = mon;
    end
  endtask
  task automatic wait_qrise();
    logic p;
    p = qtr;
    for (int i = 0; i < 400; i++) begin
      @(posedge clk);
      #1;
      if (qtr === 1'b1 && p === 1'b0) return;
      p = qtr;
    end
    num_errors++;
    $display("Error quarter clock expected rise seen none");
    give_verdict();
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_regs();
    for (int a = 0; a < 6; a++) begin
      rd(4'(a));
      chk("reset value", 21'h0, rv);
    end
    wr(`PLC_OFF_CTRL, 21'h0c);
    rd(`PLC_OFF_CTRL);
    chk("prescale bits", 21'h0c, rv);
    wr(`PLC_OFF_VOSC0, {4'h2, 7'(80 - 3), 3'h1, 7'(29 - 2)});
    rd(`PLC_OFF_VOSC0);
    chk("oscillator word", 21'h05349b, rv);
    wr(4'hf, 21'h1fffff);
    rd(4'hf);
    chk("unmapped read", 21'h0, rv);
    rd(4'h7);
    chk("unmapped read", 21'h0, rv);
    $display("test regs done");
  endtask
  task automatic t_div();
    int dv[6] = '{1, 2, 3, 4, 5, 8};
    for (int i = 0; i < 6; i++) begin
      wr(`PLC_OFF_LDIV, 21'(i));
      run(40);
      run(240);
      near("load rises", 120 / dv[i], cnt[0]);
      near("half rises", 60 / dv[i], cnt[1]);
      near("quarter rises", 30 / dv[i], cnt[2]);
    end
    $display("test div done");
  endtask
  task automatic t_gate();
    wr(`PLC_OFF_LDIV, 21'h1);
    en_s <= 1'b0;
    run(80);
    run(60);
    chk("gated rises while off", 21'h0, 21'(cnt[3]));
    rd(`PLC_OFF_STATUS);
    chk("enable sync", 21'h0, 21'(rv[2]));
    en_s <= 1'b1;
    run(80);
    run(60);
    chk("gated rises", 21'(cnt[0]), 21'(cnt[3]));
    rd(`PLC_OFF_STATUS);
    chk("enable sync", 21'h1, 21'(rv[2]));
    $display("test gate done");
  endtask
  task automatic t_align();
    wr(`PLC_OFF_LDIV, 21'h0);
    wait_qrise();
    wr(`PLC_OFF_CTRL, 21'h0d);
    wait_qrise();
    run(1);
    run(6);
    chk("video rises while stopped", 21'h0, 21'(cnt[4]));
    chk("video held", 21'h1, 21'(vco));
    chk("complement held", 21'h0, 21'(vco_n));
    wait_qrise();
    run(2);
    run(16);
    chk("video runs again", 21'h1, 21'(cnt[4] > 0));
    wait_qrise();
    wr(`PLC_OFF_CTRL, 21'h0d);
    wait_qrise();
    run(1);
    run(8);
    chk("no second stop", 21'h1, 21'(cnt[4] > 0));
    $display("test align done");
  endtask
  task automatic t_post();
    int r;
    wr(`PLC_OFF_VOSC0, {4'h2, 7'd77, 3'h0, 7'd27});
    run(20);
    run(200);
    r = cnt[4];
    wr(`PLC_OFF_VOSC0, {4'h2, 7'd77, 3'h3, 7'd27});
    run(20);
    run(200);
    near("post divide by 8", r / 8, cnt[4]);
    $display("test post done");
  endtask
  task automatic t_mux();
    vid_on <= 1'b0;
    wr(`PLC_OFF_VOSC0, {4'h2, 7'd77, 3'h0, 7'd27});
    run(20);
    run(100);
    chk("video with osc off", 21'h0, 21'(cnt[4]));
    chk("memory runs", 21'h1, 21'(cnt[5] > 0));
    wr(`PLC_OFF_VOSC0, {4'hf, 7'd77, 3'h0, 7'd27});
    run(20);
    run(100);
    chk("video from memory osc", 21'h1, 21'(cnt[4] > 0));
    rd(`PLC_OFF_STATUS);
    chk("mux flag", 21'h1, 21'(rv[3]));
    vid_on <= 1'b1;
    $display("test mux done");
  endtask
  task automatic t_dis();
    wr(`PLC_OFF_LDIV, 21'h0);
    dis_n <= 1'b0;
    xtal <= 1'b1;
    perr <= 1'b0;
    run(3);
    chk("enables", 21'h3f, 21'({ld_oe, half_oe, qtr_oe, gld_oe, vco_oe, mco_oe}));
    chk("crystal out", 21'h1, 21'(xo));
    chk("error out", 21'h0, 21'(eo));
    run(80);
    near("load rises while off", 40, cnt[0]);
    dis_n <= 1'b1;
    xtal <= 1'b0;
    perr <= 1'b1;
    run(3);
    chk("enables", 21'h0, 21'({ld_oe, half_oe, qtr_oe, gld_oe, vco_oe, mco_oe}));
    chk("crystal out", 21'h0, 21'(xo));
    chk("error out", 21'h1, 21'(eo));
    $display("test dis done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_div();
    t_gate();
    t_align();
    t_post();
    t_mux();
    t_dis();
    give_verdict();
  end
endmodule
`default_nettype wire
